// file: inc/rpl_defines.vh
// Constants for the ROM patch logic: register map, mode codes, area bounds
`ifndef RPL_DEFINES_VH
`define RPL_DEFINES_VH
`define RPL_BANK_BASE      16'h0FC0
`define RPL_BANK_LAST      16'h0FCF
`define RPL_BANK2_ADDR_LO  16'h0FC8
`define RPL_BANK2_ADDR_HI  16'h0FC9
`define RPL_MODE_CTRL      16'h002F
`define RPL_MODE_OFF       2'h0
`define RPL_MODE_JUMP      2'h1
`define RPL_MODE_BYTE1     2'h2
`define RPL_MODE_BYTE2     2'h3
`define RPL_JUMP_OPCODE    8'hFE
`define RPL_MODE_RESET     8'h00
`define RPL_ROM_START      16'hC000
`define RPL_ROM_END        16'hFFFF
`endif

// file: testbench/rpl_patch_logic_asserts.sv
// Port checker for the ROM patch logic
`timescale 1ns/1ps
module rpl_patch_logic_asserts (
  input wire        clk, reset_n, reg_wr, reg_rd, mem_rd, mem_patched,
  input wire [15:0] reg_addr, mem_addr,
  input wire [7:0]  reg_wdata, reg_rdata, rom_data, mem_data
);
  // Shadow of the mode control byte, cleared by reset like the real one
  reg [7:0] mode_reg;
  always @(posedge clk or negedge reset_n)
    if (!reset_n) mode_reg <= 8'h00;
    else if (reg_wr && reg_addr == 16'h002F) mode_reg <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_area; mem_rd && mem_addr < 16'hC000 |=> !mem_patched; endproperty
  a_area: assert property (p_area) else $error("patch outside ROM");
  property p_pass; mem_rd ##1 !mem_patched |-> mem_data == $past(rom_data); endproperty
  a_pass: assert property (p_pass) else $error("raw byte lost");
  property p_off; mem_rd && mode_reg == 8'h00 |=> !mem_patched; endproperty
  a_off: assert property (p_off) else $error("patch while disabled");
  property p_req; !mem_rd |=> !mem_patched; endproperty
  a_req: assert property (p_req) else $error("patch flag without read");
  property p_hold; !mem_rd |=> $stable(mem_data); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while idle");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_other;
    reg_rd && reg_addr != 16'h002F && reg_addr[15:4] != 12'h0FC |=> reg_rdata == 8'h00;
  endproperty
  a_other: assert property (p_other) else $error("bad read data");
  property p_mode; reg_rd && reg_addr == 16'h002F |=> reg_rdata == $past(mode_reg); endproperty
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  c_patch: cover property (mem_rd ##1 mem_patched);
  c_lock: cover property (reg_wr && reg_addr[15:4] == 12'h0FC && mode_reg != 8'h00);
  c_mode: cover property (reg_rd && reg_addr == 16'h002F);
endmodule
bind rpl_patch_logic rpl_patch_logic_asserts chk_u (.clk, .reset_n, .reg_wr, .reg_rd,
  .mem_rd, .mem_patched, .reg_addr, .mem_addr, .reg_wdata, .reg_rdata, .rom_data, .mem_data);

// file: testbench/rpl_patch_logic_test.sv
// Self-checking bench for the ROM patch logic
`timescale 1ns/1ps
`include "rpl_defines.vh"
module rpl_patch_logic_test;
  reg         clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mem_rd = 1'b0;
  reg  [15:0] reg_addr = 16'h0000, mem_addr = 16'h0000;
  reg  [7:0]  reg_wdata = 8'h00;
  wire [7:0]  reg_rdata, mem_data, rom_data;
  wire        mem_patched;
  integer     err_total = 0, check_count = 0, i;
  // Bank bytes 0 to 15 (banks 0 to 3), lowest offset in the low byte
  reg [127:0] img = 128'h2211_0100_7734_D260_0300_D254_CC33_C020;
  always #50 clk = ~clk;
  rpl_rom_model rom_u (.addr(mem_addr), .data(rom_data));
  rpl_patch_logic dut_u (.clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .mem_addr, .mem_rd, .rom_data, .mem_data, .mem_patched);
  function [7:0] r(input [15:0] a);
    r = a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task chk(input [7:0] s, input [7:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      reg_addr = a; reg_wdata = d; reg_wr = 1'b1; reg_rd = 1'b0; mem_rd = 1'b0;
      @(posedge clk); #1;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      reg_addr = a; reg_rd = 1'b1; reg_wr = 1'b0; mem_rd = 1'b0;
      @(posedge clk); #1;
      chk(reg_rdata, e);
    end
  endtask
  // Fetches stay back to back; the caller drops mem_rd when done
  task f(input [15:0] a, input [7:0] e, input p);
    begin
      mem_addr = a; mem_rd = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
      @(posedge clk); #1;
      chk(mem_data, e);
      chk({7'h00, mem_patched}, {7'h00, p});
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rd(`RPL_MODE_CTRL, `RPL_MODE_RESET);
    f(16'hFFFE, r(16'hFFFE), 1'b0);
    for (i = 0; i < 16; i = i + 1) wr(`RPL_BANK_BASE + i, img[8*i+:8]);
    wr(`RPL_MODE_CTRL, 8'hE7);
    rd(`RPL_MODE_CTRL, 8'hE7);
    rd(16'h0FD0, 8'h00);
    rd(`RPL_BANK2_ADDR_LO, 8'h60);
    rd(`RPL_BANK2_ADDR_HI, 8'hD2);
    f(16'hC020, 8'h33, 1'b1);
    f(16'hC021, 8'hCC, 1'b1);
    f(16'hC022, r(16'hC022), 1'b0);
    f(16'hD254, `RPL_JUMP_OPCODE, 1'b1);
    f(16'hD255, 8'h00, 1'b1);
    f(16'hD256, 8'h03, 1'b1);
    f(16'hD260, 8'h34, 1'b1);
    f(16'hD261, r(16'hD261), 1'b0);
    f(16'h0100, r(16'h0100), 1'b0);
    wr(16'h0FC0, 8'h40);
    rd(16'h0FC0, 8'h20);
    f(16'hC020, 8'h33, 1'b1);
    wr(`RPL_MODE_CTRL, 8'h00);
    f(16'hC020, r(16'hC020), 1'b0);
    wr(16'h0FC0, 8'h40);
    wr(`RPL_MODE_CTRL, 8'h03);
    f(16'hC040, 8'h33, 1'b1);
    mem_rd = 1'b0;
    @(posedge clk); #1;
    chk(mem_data, 8'h33);
    test_done;
  end
  initial begin
    #20000;
    err_total = err_total + 1;
    test_done;
  end
endmodule

// file: testbench/rpl_rom_model.sv
// Behavioural user ROM answering in the same cycle
`timescale 1ns/1ps
module rpl_rom_model (
  input  wire [15:0] addr,
  output wire [7:0]  data
);
  // Both address bytes shape the content so a wrong address shows
  assign data = addr[7:0] ^ addr[15:8] ^ 8'h5A;
endmodule

// file: verilog/rpl_bank_store.v
// Bank register store: 4 banks x 4 bytes, registered read data
`timescale 1ns/1ps
`include "rpl_defines.vh"
module rpl_bank_store #(
  parameter BANKS = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Write port
  input  wire        wr_en,
  input  wire [3:0]  wr_idx,
  input  wire [7:0]  wr_data,
  // Read port
  input  wire [3:0]  rd_idx,
  output reg  [7:0]  rd_data,
  // Flat bank contents for the comparators
  output wire [BANKS*32-1:0] flat
);
  reg [7:0] mem_reg [0:BANKS*4-1];
  integer i;
  genvar g;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < BANKS*4; i = i + 1)
        mem_reg[i] <= 8'h00;
      rd_data <= 8'h00;
    end else begin
      if (wr_en)
        mem_reg[wr_idx] <= wr_data;
      rd_data <= mem_reg[rd_idx];
    end
  end
  generate
    for (g = 0; g < BANKS*4; g = g + 1) begin : g_flat
      assign flat[g*8 +: 8] = mem_reg[g];
    end
  endgenerate
endmodule

// file: verilog/rpl_patch_logic.v
// ROM patch logic: bank registers, mode control and byte substitution
// Functional notes
// - Four independent banks, each patches one location.
// - Sixteen-bit address, low byte then high byte.
// - Jump mode gives FE, low, high bytes.
// - Jump mode data read returns FE.
// - Mode 10 replaces one byte with low.
// - High data byte unused in one-byte mode.
// - Mode 11 replaces two bytes, low then high.
// - Substitute on fetches and on data reads.
// - Opcode or operand bytes patched the same.
// - Bank registers locked while that bank's mode nonzero.
// - Reset clears mode control, banks disabled.
// - Patch address must lie inside user ROM area; offsets past FFFF wrap to 0000.
`timescale 1ns/1ps
`include "rpl_defines.vh"
module rpl_patch_logic #(
  parameter BANKS = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // CPU register access
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // CPU memory access and ROM data
  input  wire [15:0] mem_addr,
  input  wire        mem_rd,
  input  wire [7:0]  rom_data,
  output reg  [7:0]  mem_data,
  output reg         mem_patched
);
  reg        rst_s1_reg;
  reg        rst_s2_reg;
  reg  [7:0] mode_reg;
  reg        sel_mode_reg;
  reg        sel_bank_reg;
  reg  [7:0] mode_rd_reg;
  wire [BANKS*32-1:0] flat;
  wire [7:0] store_rdata;
  wire       in_bank_space;
  wire [3:0] bank_idx;
  wire [1:0] wr_bank_mode;
  wire       store_wr;
  reg  [7:0] sub_byte;
  reg        sub_hit;
  reg  [15:0] p_addr;
  reg  [15:0] d;
  reg  [1:0]  m;
  integer b;

  // Reset released through two flops so every register leaves reset together
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  function [1:0] bank_mode;
    input [7:0] modes;
    input [1:0] idx;
    begin
      bank_mode = modes[idx*2 +: 2];
    end
  endfunction

  function in_user_rom;
    input [15:0] a;
    begin
      in_user_rom = (a >= `RPL_ROM_START) && (a <= `RPL_ROM_END);
    end
  endfunction

  assign in_bank_space = (reg_addr >= `RPL_BANK_BASE) && (reg_addr <= `RPL_BANK_LAST);
  assign bank_idx      = reg_addr[3:0];
  assign wr_bank_mode  = bank_mode(mode_reg, bank_idx[3:2]);
  // Write is accepted by the bus but dropped while the bank is armed
  assign store_wr = reg_wr && in_bank_space && (wr_bank_mode == `RPL_MODE_OFF);

  rpl_bank_store #(
    .BANKS   (BANKS)
  ) u_store (
    .clk     (clk),
    .rst_n   (rst_s2_reg),
    .wr_en   (store_wr),
    .wr_idx  (bank_idx),
    .wr_data (reg_wdata),
    .rd_idx  (bank_idx),
    .rd_data (store_rdata),
    .flat    (flat)
  );

  // Mode control register; reset value leaves every bank disabled
  always @(posedge clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      mode_reg     <= `RPL_MODE_RESET;
      sel_mode_reg <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == `RPL_MODE_CTRL))
        mode_reg <= reg_wdata;
      sel_mode_reg <= reg_rd && (reg_addr == `RPL_MODE_CTRL);
    end
  end

  // Read selects and the mode snapshot line up with the store's registered
  // read port, so every readback appears one cycle after the request
  always @(posedge clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      sel_bank_reg <= 1'b0;
      mode_rd_reg  <= 8'h00;
    end else begin
      sel_bank_reg <= reg_rd && in_bank_space;
      mode_rd_reg  <= mode_reg;
    end
  end

  // Both sources are flops; only the select mux sits after them
  always @* begin
    if (sel_bank_reg)
      reg_rdata = store_rdata;
    else if (sel_mode_reg)
      reg_rdata = mode_rd_reg;
    else
      reg_rdata = 8'h00;
  end

  // Substitution: each bank compares independently; lowest bank wins on overlap
  always @* begin
    sub_byte = 8'h00;
    sub_hit  = 1'b0;
    p_addr   = 16'h0000;
    d        = 16'h0000;
    m        = 2'b00;
    for (b = BANKS-1; b >= 0; b = b - 1) begin
      p_addr = flat[b*32 +: 16];
      d      = flat[b*32+16 +: 16];
      m      = bank_mode(mode_reg, b[1:0]);
      if (in_user_rom(p_addr)) begin
        case (m)
          `RPL_MODE_JUMP: begin
            if (mem_addr == p_addr) begin
              sub_byte = `RPL_JUMP_OPCODE;
              sub_hit  = 1'b1;
            end else if (mem_addr == p_addr + 16'h0001) begin
              sub_byte = d[7:0];
              sub_hit  = 1'b1;
            end else if (mem_addr == p_addr + 16'h0002) begin
              sub_byte = d[15:8];
              sub_hit  = 1'b1;
            end
          end
          `RPL_MODE_BYTE1: begin
            if (mem_addr == p_addr) begin
              sub_byte = d[7:0];
              sub_hit  = 1'b1;
            end
          end
          `RPL_MODE_BYTE2: begin
            if (mem_addr == p_addr) begin
              sub_byte = d[7:0];
              sub_hit  = 1'b1;
            end else if (mem_addr == p_addr + 16'h0001) begin
              sub_byte = d[15:8];
              sub_hit  = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Registered data towards the CPU, same path for fetch and data read
  always @(posedge clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      mem_data    <= 8'h00;
      mem_patched <= 1'b0;
    end else if (mem_rd) begin
      mem_data    <= sub_hit ? sub_byte : rom_data;
      mem_patched <= sub_hit;
    end else begin
      mem_patched <= 1'b0;
    end
  end

endmodule
